// [hdl/aemf_pkg.sv]
// What this block does
// [RULE_01] register port takes valid read address promptly
// [RULE_02] register read valid only with data and response
// [RULE_03] register port reset is active low
// [RULE_04] unmapped register accesses still complete
// [RULE_05] fixed bursts unsupported; host never issues them
// [RULE_06] reads and writes granted round robin
// [RULE_07] one memory access at a time
// [RULE_08] every read beat carries data and response
// [RULE_09] memory read error gives slave error
// [RULE_10] write response after last memory write
// [RULE_11] memory clock is half the bus clock
// [RULE_12] host programs configuration before memory use
// [RULE_13] memory pins move only after acceptance
// [RULE_14] unmapped register reads zero, answers okay
package aemf_pkg;
	localparam int          AW         = 32;
	localparam int          DW         = 32;
	localparam int          LW         = 8;
	localparam int          FIFO_DEPTH = 32;
	localparam logic [1:0]  BURST_FIXED = 2'h0;
	localparam logic [1:0]  BURST_INCR  = 2'h1;
	localparam logic [1:0]  BURST_WRAP  = 2'h2;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [AW-1:0] BEAT_BYTES = 32'h4;
	localparam logic [AW-1:0] REG_CFG    = 32'h0;
	localparam logic [DW-1:0] CFG_RST    = 32'h0;

	typedef enum logic [2:0] {
		D_IDLE    = 3'b000,
		D_WR_MEM  = 3'b001,
		D_WR_WAIT = 3'b010,
		D_BRESP   = 3'b011,
		D_RD_MEM  = 3'b100,
		D_RD_WAIT = 3'b101,
		D_RD_OUT  = 3'b110
	} aemf_dstate_t;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_DATA = 2'b01,
		H_RESP = 2'b10
	} aemf_hstate_t;
endpackage : aemf_pkg

// [hdl/aemf_if.sv]
`timescale 1ns/10ps
interface aemf_if;
	import aemf_pkg::*;
	// register port
	logic          reg_aresetn;
	logic [AW-1:0] reg_awaddr;
	logic          reg_awvalid;
	logic          reg_awready;
	logic [DW-1:0] reg_wdata;
	logic          reg_wvalid;
	logic          reg_wready;
	logic [1:0]    reg_bresp;
	logic          reg_bvalid;
	logic          reg_bready;
	logic [AW-1:0] reg_araddr;
	logic          reg_arvalid;
	logic          reg_arready;
	logic [DW-1:0] reg_rdata;
	logic [1:0]    reg_rresp;
	logic          reg_rvalid;
	logic          reg_rready;
	// memory-mapped port
	logic [AW-1:0] awaddr;
	logic [LW-1:0] awlen;
	logic [1:0]    awburst;
	logic          awvalid;
	logic          awready;
	logic [DW-1:0] wdata;
	logic          wlast;
	logic          wvalid;
	logic          wready;
	logic [1:0]    bresp;
	logic          bvalid;
	logic          bready;
	logic [AW-1:0] araddr;
	logic [LW-1:0] arlen;
	logic [1:0]    arburst;
	logic          arvalid;
	logic          arready;
	logic [DW-1:0] rdata;
	logic [1:0]    rresp;
	logic          rlast;
	logic          rvalid;
	logic          rready;

	modport dev (
		input  reg_aresetn, reg_awaddr, reg_awvalid, reg_wdata, reg_wvalid,
		input  reg_bready, reg_araddr, reg_arvalid, reg_rready,
		output reg_awready, reg_wready, reg_bresp, reg_bvalid,
		output reg_arready, reg_rdata, reg_rresp, reg_rvalid,
		input  awaddr, awlen, awburst, awvalid, wdata, wlast, wvalid,
		input  bready, araddr, arlen, arburst, arvalid, rready,
		output awready, wready, bresp, bvalid, arready,
		output rdata, rresp, rlast, rvalid
	);
	modport host (
		output reg_aresetn, reg_awaddr, reg_awvalid, reg_wdata, reg_wvalid,
		output reg_bready, reg_araddr, reg_arvalid, reg_rready,
		input  reg_awready, reg_wready, reg_bresp, reg_bvalid,
		input  reg_arready, reg_rdata, reg_rresp, reg_rvalid,
		output awaddr, awlen, awburst, awvalid, wdata, wlast, wvalid,
		output bready, araddr, arlen, arburst, arvalid, rready,
		input  awready, wready, bresp, bvalid, arready,
		input  rdata, rresp, rlast, rvalid
	);
endinterface : aemf_if

// [hdl/aemf_dev.sv]
`timescale 1ns/10ps
// write data buffer; in_ready is registered so it can drive a port
module aemf_fifo
	import aemf_pkg::*;
#(
	parameter int WIDTH = DW,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0]    wp_r;
	logic [PW-1:0]    rp_r;
	logic [PW:0]      cnt_r;
	logic [PW:0]      cnt_nxt;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rp_r];
	assign cnt_nxt   = cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};

	// storage has no reset, only pointers, count and ready do
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end

	// pointers, fill level and registered ready
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wp_r     <= '0;
			rp_r     <= '0;
			cnt_r    <= '0;
			in_ready <= 1'b0;
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			cnt_r    <= cnt_nxt;
			in_ready <= (cnt_nxt != (PW+1)'(DEPTH));
		end
	end
endmodule : aemf_fifo

module aemf_dev
	import aemf_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	aemf_if.dev                bus,
	output logic               mem_clk,
	output logic               mem_req,
	output logic               mem_we,
	output logic [AW-1:0]      mem_addr,
	output logic [DW-1:0]      mem_wdata,
	input  wire logic [DW-1:0] mem_rdata,
	input  wire logic          mem_ack,
	input  wire logic          mem_err,
	output logic [DW-1:0]      mem_cfg
);
	aemf_dstate_t  st_r;
	logic [AW-1:0] addr_r;
	logic [LW-1:0] len_r;
	logic [LW-1:0] left_r;
	logic [1:0]    burst_r;
	logic          fixed_r;
	logic          last_wr_r;
	logic          werr_r;
	logic          lite_rst;
	logic [DW-1:0] fq_data;
	logic          fq_valid;
	logic          fq_pop;

	// next beat address; wrap bursts fold at their own size
	function automatic logic [AW-1:0] next_addr(
		input logic [AW-1:0] a,
		input logic [LW-1:0] l,
		input logic [1:0]    b
	);
		logic [AW-1:0] m;
		m = (({{(AW-LW){1'b0}}, l} + 1'b1) << 2) - 1'b1;
		if (b == BURST_WRAP) begin
			next_addr = (a & ~m) | ((a + BEAT_BYTES) & m);
		end else begin
			next_addr = a + BEAT_BYTES;
		end
	endfunction : next_addr

	// write beats queue here so memory stalls push back on wready
	aemf_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) aemf_fifo_inst (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_data   (bus.wdata),
		.in_valid  (bus.wvalid),
		.in_ready  (bus.wready),
		.out_data  (fq_data),
		.out_valid (fq_valid),
		.out_ready (fq_pop)
	);
	assign fq_pop = (st_r == D_WR_MEM) && fq_valid;

	// burst engine: one burst, one memory access in flight
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r        <= D_IDLE;
			addr_r      <= '0;
			len_r       <= '0;
			left_r      <= '0;
			burst_r     <= BURST_INCR;
			fixed_r     <= 1'b0;
			last_wr_r   <= 1'b0;
			werr_r      <= 1'b0;
			bus.awready <= 1'b0;
			bus.arready <= 1'b0;
			bus.bvalid  <= 1'b0;
			bus.bresp   <= RESP_OKAY;
			bus.rvalid  <= 1'b0;
			bus.rdata   <= '0;
			bus.rresp   <= RESP_OKAY;
			bus.rlast   <= 1'b0;
			mem_req     <= 1'b0;
			mem_we      <= 1'b0;
			mem_addr    <= '0;
			mem_wdata   <= '0;
		end else begin
			bus.awready <= 1'b0;
			bus.arready <= 1'b0;
			case (st_r)
			D_IDLE: begin
				// a waiting channel that did not go last wins a tie
				if (bus.awvalid && (!bus.arvalid || !last_wr_r)) begin // RULE_06
					bus.awready <= 1'b1;
					addr_r      <= bus.awaddr;
					len_r       <= bus.awlen;
					left_r      <= bus.awlen;
					burst_r     <= bus.awburst;
					fixed_r     <= (bus.awburst == BURST_FIXED); // RULE_05
					werr_r      <= 1'b0;
					st_r        <= D_WR_MEM;
				end else if (bus.arvalid) begin // RULE_06
					bus.arready <= 1'b1;
					addr_r      <= bus.araddr;
					len_r       <= bus.arlen;
					left_r      <= bus.arlen;
					burst_r     <= bus.arburst;
					fixed_r     <= (bus.arburst == BURST_FIXED); // RULE_05
					st_r        <= D_RD_MEM;
				end
			end
			D_WR_MEM: begin
				if (fq_valid) begin
					if (fixed_r) begin
						// unsupported burst: drain beats, touch no pins
						werr_r <= 1'b1; // RULE_05
						if (left_r == '0) begin
							bus.bvalid <= 1'b1;
							bus.bresp  <= RESP_SLVERR;
							st_r       <= D_BRESP;
						end else begin
							left_r <= left_r - 1'b1;
						end
					end else begin
						mem_req   <= 1'b1; // RULE_13
						mem_we    <= 1'b1;
						mem_addr  <= addr_r;
						mem_wdata <= fq_data;
						st_r      <= D_WR_WAIT;
					end
				end
			end
			D_WR_WAIT: begin
				if (mem_ack) begin
					mem_req <= 1'b0; // RULE_07
					addr_r  <= next_addr(addr_r, len_r, burst_r);
					if (left_r == '0) begin
						bus.bvalid <= 1'b1; // RULE_10
						bus.bresp  <= (werr_r || mem_err) ? RESP_SLVERR : RESP_OKAY;
						st_r       <= D_BRESP;
					end else begin
						werr_r <= werr_r || mem_err;
						left_r <= left_r - 1'b1;
						st_r   <= D_WR_MEM;
					end
				end
			end
			D_BRESP: begin
				if (bus.bready) begin
					bus.bvalid <= 1'b0;
					last_wr_r  <= 1'b1;
					st_r       <= D_IDLE;
				end
			end
			D_RD_MEM: begin
				if (fixed_r) begin
					bus.rvalid <= 1'b1;
					bus.rdata  <= '0;
					bus.rresp  <= RESP_SLVERR; // RULE_05
					bus.rlast  <= (left_r == '0);
					st_r       <= D_RD_OUT;
				end else begin
					mem_req  <= 1'b1; // RULE_13
					mem_we   <= 1'b0;
					mem_addr <= addr_r;
					st_r     <= D_RD_WAIT;
				end
			end
			D_RD_WAIT: begin
				if (mem_ack) begin
					mem_req    <= 1'b0; // RULE_07
					addr_r     <= next_addr(addr_r, len_r, burst_r);
					bus.rvalid <= 1'b1; // RULE_08
					bus.rdata  <= mem_rdata;
					bus.rresp  <= mem_err ? RESP_SLVERR : RESP_OKAY; // RULE_09
					bus.rlast  <= (left_r == '0);
					st_r       <= D_RD_OUT;
				end
			end
			D_RD_OUT: begin
				if (bus.rready) begin
					bus.rvalid <= 1'b0;
					if (bus.rlast) begin
						last_wr_r <= 1'b0;
						st_r      <= D_IDLE;
					end else begin
						left_r <= left_r - 1'b1;
						st_r   <= D_RD_MEM;
					end
				end
			end
			default: begin
				st_r <= D_IDLE;
			end
			endcase
		end
	end

	// memory clock at half rate, quiet outside accesses
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mem_clk <= 1'b0;
		end else begin
			mem_clk <= mem_req ? ~mem_clk : 1'b0; // RULE_11
		end
	end

	// register port held in reset by its own low reset as well
	assign lite_rst = !rst_n || !bus.reg_aresetn; // RULE_03

	// register port: address and data taken together, one at a time
	always_ff @(posedge clk) begin
		if (lite_rst) begin
			bus.reg_awready <= 1'b0;
			bus.reg_wready  <= 1'b0;
			bus.reg_bvalid  <= 1'b0;
			bus.reg_bresp   <= RESP_OKAY;
			bus.reg_arready <= 1'b0;
			bus.reg_rvalid  <= 1'b0;
			bus.reg_rdata   <= '0;
			bus.reg_rresp   <= RESP_OKAY;
			mem_cfg         <= CFG_RST;
		end else begin
			bus.reg_awready <= 1'b0;
			bus.reg_wready  <= 1'b0;
			bus.reg_arready <= 1'b0;
			if (bus.reg_awvalid && bus.reg_wvalid && !bus.reg_awready
				&& !bus.reg_bvalid) begin
				bus.reg_awready <= 1'b1;
				bus.reg_wready  <= 1'b1;
				bus.reg_bvalid  <= 1'b1; // RULE_04
				bus.reg_bresp   <= RESP_OKAY; // RULE_14
				if (bus.reg_awaddr == REG_CFG) begin
					mem_cfg <= bus.reg_wdata;
				end
			end else if (bus.reg_bvalid && bus.reg_bready) begin
				bus.reg_bvalid <= 1'b0;
			end
			if (bus.reg_arvalid && !bus.reg_arready && !bus.reg_rvalid) begin
				bus.reg_arready <= 1'b1; // RULE_01
				bus.reg_rvalid  <= 1'b1; // RULE_02
				bus.reg_rresp   <= RESP_OKAY; // RULE_14
				bus.reg_rdata   <= (bus.reg_araddr == REG_CFG) ? mem_cfg : '0;
			end else if (bus.reg_rvalid && bus.reg_rready) begin
				bus.reg_rvalid <= 1'b0;
			end
		end
	end
endmodule : aemf_dev

// [hdl/aemf_host.sv]
`timescale 1ns/10ps
module aemf_host
	import aemf_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	aemf_if.host               bus,
	input  wire logic          cmd_valid,
	output logic               cmd_ready,
	input  wire logic          cmd_write,
	input  wire logic          cmd_reg,
	input  wire logic [AW-1:0] cmd_addr,
	input  wire logic [LW-1:0] cmd_len,
	input  wire logic [1:0]    cmd_burst,
	input  wire logic          wd_valid,
	input  wire logic [DW-1:0] wd_data,
	output logic               wd_ready,
	output logic               rsp_valid,
	output logic [DW-1:0]      rsp_data,
	output logic [1:0]         rsp_resp,
	output logic               rsp_last,
	output logic               done_valid,
	output logic [1:0]         done_resp
);
	aemf_hstate_t  st_r;
	logic          reg_r;
	logic [LW-1:0] left_r;

	// register port reset follows system reset, released after it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bus.reg_aresetn <= 1'b0;
		end else begin
			bus.reg_aresetn <= 1'b1; // RULE_03
		end
	end

	// command sequencer: one transaction outstanding
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r            <= H_IDLE;
			reg_r           <= 1'b0;
			left_r          <= '0;
			cmd_ready       <= 1'b0;
			wd_ready        <= 1'b0;
			rsp_valid       <= 1'b0;
			rsp_data        <= '0;
			rsp_resp        <= RESP_OKAY;
			rsp_last        <= 1'b0;
			done_valid      <= 1'b0;
			done_resp       <= RESP_OKAY;
			bus.reg_awaddr  <= '0;
			bus.reg_awvalid <= 1'b0;
			bus.reg_wdata   <= '0;
			bus.reg_wvalid  <= 1'b0;
			bus.reg_bready  <= 1'b0;
			bus.reg_araddr  <= '0;
			bus.reg_arvalid <= 1'b0;
			bus.reg_rready  <= 1'b0;
			bus.awaddr      <= '0;
			bus.awlen       <= '0;
			bus.awburst     <= BURST_INCR;
			bus.awvalid     <= 1'b0;
			bus.wdata       <= '0;
			bus.wlast       <= 1'b0;
			bus.wvalid      <= 1'b0;
			bus.bready      <= 1'b0;
			bus.araddr      <= '0;
			bus.arlen       <= '0;
			bus.arburst     <= BURST_INCR;
			bus.arvalid     <= 1'b0;
			bus.rready      <= 1'b0;
		end else begin
			rsp_valid  <= 1'b0;
			done_valid <= 1'b0;
			if (bus.awvalid && bus.awready) begin
				bus.awvalid <= 1'b0;
			end
			if (bus.arvalid && bus.arready) begin
				bus.arvalid <= 1'b0;
			end
			if (bus.reg_arvalid && bus.reg_arready) begin
				bus.reg_arvalid <= 1'b0;
			end
			case (st_r)
			H_IDLE: begin
				cmd_ready <= 1'b1;
				if (cmd_valid && cmd_ready) begin
					cmd_ready <= 1'b0;
					reg_r     <= cmd_reg;
					left_r    <= cmd_reg ? '0 : cmd_len;
					if (cmd_write) begin
						wd_ready        <= 1'b1;
						bus.reg_awaddr  <= cmd_addr;
						bus.awaddr      <= cmd_addr;
						bus.awlen       <= cmd_len;
						// fixed requests go out as incrementing
						bus.awburst     <= (cmd_burst == BURST_FIXED) ?
							BURST_INCR : cmd_burst; // RULE_05
						bus.awvalid     <= !cmd_reg;
						st_r            <= H_DATA;
					end else begin
						bus.reg_araddr  <= cmd_addr;
						bus.reg_arvalid <= cmd_reg;
						bus.reg_rready  <= cmd_reg;
						bus.araddr      <= cmd_addr;
						bus.arlen       <= cmd_len;
						bus.arburst     <= (cmd_burst == BURST_FIXED) ?
							BURST_INCR : cmd_burst; // RULE_05
						bus.arvalid     <= !cmd_reg;
						bus.rready      <= !cmd_reg;
						st_r            <= H_RESP;
					end
				end
			end
			H_DATA: begin
				if (wd_ready && wd_valid) begin
					wd_ready <= 1'b0;
					if (reg_r) begin
						bus.reg_wdata   <= wd_data;
						bus.reg_awvalid <= 1'b1;
						bus.reg_wvalid  <= 1'b1;
					end else begin
						bus.wdata  <= wd_data;
						bus.wvalid <= 1'b1;
						bus.wlast  <= (left_r == '0);
					end
				end
				if (bus.reg_awvalid && bus.reg_awready) begin
					bus.reg_awvalid <= 1'b0;
					bus.reg_wvalid  <= 1'b0;
					bus.reg_bready  <= 1'b1;
					st_r            <= H_RESP;
				end
				if (bus.wvalid && bus.wready) begin
					bus.wvalid <= 1'b0;
					if (bus.wlast) begin
						bus.bready <= 1'b1;
						st_r       <= H_RESP;
					end else begin
						left_r   <= left_r - 1'b1;
						wd_ready <= 1'b1;
					end
				end
			end
			H_RESP: begin
				// every completion ends in one done pulse
				if (bus.bvalid && bus.bready) begin
					bus.bready <= 1'b0;
					done_valid <= 1'b1;
					done_resp  <= bus.bresp;
					st_r       <= H_IDLE;
				end
				if (bus.reg_bvalid && bus.reg_bready) begin
					bus.reg_bready <= 1'b0;
					done_valid     <= 1'b1;
					done_resp      <= bus.reg_bresp;
					st_r           <= H_IDLE;
				end
				if (bus.rvalid && bus.rready) begin
					rsp_valid <= 1'b1;
					rsp_data  <= bus.rdata;
					rsp_resp  <= bus.rresp;
					rsp_last  <= bus.rlast;
					if (bus.rlast) begin
						bus.rready <= 1'b0;
						done_valid <= 1'b1;
						done_resp  <= bus.rresp;
						st_r       <= H_IDLE;
					end
				end
				if (bus.reg_rvalid && bus.reg_rready) begin
					bus.reg_rready <= 1'b0;
					rsp_valid      <= 1'b1;
					rsp_data       <= bus.reg_rdata;
					rsp_resp       <= bus.reg_rresp;
					rsp_last       <= 1'b1;
					done_valid     <= 1'b1;
					done_resp      <= bus.reg_rresp;
					st_r           <= H_IDLE;
				end
			end
			default: begin
				st_r <= H_IDLE;
			end
			endcase
		end
	end
endmodule : aemf_host

// [dv/aemf_props.sv]
`timescale 1ns/10ps
// watches the link between both ends; sees interface signals only
module aemf_props
	import aemf_pkg::*;
(
	input wire logic          clk,
	input wire logic          rst_n,
	input wire logic          reg_aresetn,
	input wire logic          reg_awvalid,
	input wire logic          reg_wvalid,
	input wire logic          reg_awready,
	input wire logic          reg_wready,
	input wire logic          reg_bvalid,
	input wire logic [1:0]    reg_bresp,
	input wire logic [AW-1:0] reg_araddr,
	input wire logic          reg_arvalid,
	input wire logic          reg_arready,
	input wire logic          reg_rvalid,
	input wire logic          reg_rready,
	input wire logic [DW-1:0] reg_rdata,
	input wire logic [1:0]    reg_rresp,
	input wire logic [LW-1:0] awlen,
	input wire logic [1:0]    awburst,
	input wire logic          awvalid,
	input wire logic          awready,
	input wire logic          wvalid,
	input wire logic          wready,
	input wire logic          bvalid,
	input wire logic          bready,
	input wire logic [LW-1:0] arlen,
	input wire logic [1:0]    arburst,
	input wire logic          arvalid,
	input wire logic          arready,
	input wire logic          rvalid,
	input wire logic          rready,
	input wire logic          rlast
);
	logic [LW-1:0] wlen_r;
	logic [LW-1:0] rlen_r;
	logic [8:0]    wcnt_r;
	logic [8:0]    rcnt_r;
	logic          wbusy_r;
	logic          rbusy_r;

	// lengths of the bursts in flight
	always_ff @(posedge clk) begin
		if (awvalid && awready) wlen_r <= awlen;
		if (arvalid && arready) rlen_r <= arlen;
	end

	// write side: beats and open burst, both closed by the response
	always_ff @(posedge clk) begin
		if (!rst_n || (bvalid && bready)) begin
			wcnt_r  <= '0;
			wbusy_r <= 1'b0;
		end else begin
			if (wvalid && wready) wcnt_r <= wcnt_r + 9'h1;
			if (awvalid && awready) wbusy_r <= 1'b1;
		end
	end

	// read side: beats returned and open burst
	always_ff @(posedge clk) begin
		if (!rst_n || (rvalid && rready && rlast)) begin
			rcnt_r  <= '0;
			rbusy_r <= 1'b0;
		end else begin
			if (rvalid && rready) rcnt_r <= rcnt_r + 9'h1;
			if (arvalid && arready) rbusy_r <= 1'b1;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_REG_RD_ANSWER: assert property (disable iff (!rst_n || !reg_aresetn)
		reg_arvalid && !reg_arready && !reg_rvalid |=> reg_arready && reg_rvalid)
		else $error("register read not answered next cycle");
	AST_REG_RD_HOLD: assert property (disable iff (!rst_n || !reg_aresetn)
		$rose(reg_rvalid) |-> $past(reg_arvalid && !reg_arready))
		else $error("register read valid with no address");
	AST_REG_WR_ANSWER: assert property (disable iff (!rst_n || !reg_aresetn)
		reg_awvalid && reg_wvalid && !reg_awready && !reg_bvalid
		|=> reg_awready && reg_wready && reg_bvalid)
		else $error("register write not completed next cycle");
	AST_REG_RESET: assert property (!reg_aresetn |=> !reg_rvalid && !reg_bvalid)
		else $error("register port active during its reset");
	AST_REG_ZERO: assert property (disable iff (!rst_n || !reg_aresetn)
		$rose(reg_rvalid) && $past(reg_araddr) != REG_CFG
		|-> reg_rdata == '0 && reg_rresp == RESP_OKAY)
		else $error("unmapped register read not zero okay");
	AST_REG_WR_OKAY: assert property ($rose(reg_bvalid) |-> reg_bresp == RESP_OKAY)
		else $error("register write response not okay");
	AST_NO_FIXED: assert property ((!arvalid || arburst != BURST_FIXED) &&
		(!awvalid || awburst != BURST_FIXED))
		else $error("fixed burst issued on the link");
	AST_ONE_BURST: assert property (!(wbusy_r && rbusy_r))
		else $error("read and write bursts open together");
	AST_WR_AFTER_LAST: assert property ($rose(bvalid)
		|-> wcnt_r == {1'b0, wlen_r} + 9'h1)
		else $error("write response before last beat");
	AST_RLAST: assert property (rvalid |-> rlast == (rcnt_r == {1'b0, rlen_r}))
		else $error("read last flag on wrong beat");
endmodule : aemf_props

// [dv/aemf_bench.sv]
`timescale 1ns/10ps
module aemf_bench;
	import aemf_pkg::*;
	logic          clk, rst_n, cmd_valid, cmd_ready, cmd_write, cmd_reg;
	logic          wd_valid, wd_ready, rsp_valid, rsp_last, done_valid;
	logic          mem_clk, mem_req, mem_we, mem_ack, mem_err;
	logic          mem_open, full_seen, prev_req, prev_mclk;
	logic [AW-1:0] cmd_addr, mem_addr, err_addr;
	logic [DW-1:0] wd_data, rsp_data, mem_wdata, mem_rdata, mem_cfg;
	logic [LW-1:0] cmd_len;
	logic [1:0]    cmd_burst, rsp_resp, done_resp;
	logic [DW-1:0] mem_arr [0:255];
	logic [34:0]   rsp_q [$];
	logic [1:0]    done_q [$];
	int            num_errors, num_checks, acc_cnt, wait_cnt, mem_delay, cycles;

	aemf_if bus_if ();
	aemf_dev aemf_dev_inst (.clk(clk), .rst_n(rst_n), .bus(bus_if),
		.mem_clk(mem_clk), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .mem_err(mem_err), .mem_cfg(mem_cfg));
	aemf_host aemf_host_inst (.clk(clk), .rst_n(rst_n), .bus(bus_if),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
		.cmd_reg(cmd_reg), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
		.cmd_burst(cmd_burst), .wd_valid(wd_valid), .wd_data(wd_data),
		.wd_ready(wd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_resp(rsp_resp), .rsp_last(rsp_last), .done_valid(done_valid),
		.done_resp(done_resp));
	aemf_props aemf_props_inst (.clk(clk), .rst_n(rst_n),
		.reg_aresetn(bus_if.reg_aresetn), .reg_awvalid(bus_if.reg_awvalid),
		.reg_wvalid(bus_if.reg_wvalid), .reg_awready(bus_if.reg_awready),
		.reg_wready(bus_if.reg_wready), .reg_bvalid(bus_if.reg_bvalid),
		.reg_bresp(bus_if.reg_bresp), .reg_araddr(bus_if.reg_araddr),
		.reg_arvalid(bus_if.reg_arvalid), .reg_arready(bus_if.reg_arready),
		.reg_rvalid(bus_if.reg_rvalid), .reg_rready(bus_if.reg_rready),
		.reg_rdata(bus_if.reg_rdata), .reg_rresp(bus_if.reg_rresp),
		.awlen(bus_if.awlen), .awburst(bus_if.awburst),
		.awvalid(bus_if.awvalid), .awready(bus_if.awready),
		.wvalid(bus_if.wvalid), .wready(bus_if.wready),
		.bvalid(bus_if.bvalid), .bready(bus_if.bready),
		.arlen(bus_if.arlen), .arburst(bus_if.arburst),
		.arvalid(bus_if.arvalid), .arready(bus_if.arready),
		.rvalid(bus_if.rvalid), .rready(bus_if.rready), .rlast(bus_if.rlast));

	always #50 clk = ~clk;

	// cut a hang short; the longest burst needs about 1300 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			complete_run();
		end
	end

	// collect pulses of the user side, and watch the link for a burst in flight
	always @(posedge clk) begin
		if (rsp_valid === 1'b1) rsp_q.push_back({rsp_last, rsp_resp, rsp_data});
		if (done_valid === 1'b1) done_q.push_back(done_resp);
		if (bus_if.wvalid && !bus_if.wready) full_seen <= 1'b1;
		if (!rst_n || (bus_if.bvalid && bus_if.bready) ||
			(bus_if.rvalid && bus_if.rready && bus_if.rlast)) mem_open <= 1'b0;
		else if ((bus_if.awvalid && bus_if.awready) ||
			(bus_if.arvalid && bus_if.arready)) mem_open <= 1'b1;
	end

	// memory answers after mem_delay cycles; idle data lines keep changing
	always @(negedge clk) begin
		if (mem_req === 1'b1 && !mem_ack && wait_cnt >= mem_delay) begin
			mem_ack <= 1'b1;
			mem_err <= (mem_addr == err_addr);
			acc_cnt <= acc_cnt + 1;
			wait_cnt <= 0;
			mem_rdata <= mem_we ? ~mem_rdata : mem_arr[mem_addr[9:2]];
			if (mem_we) mem_arr[mem_addr[9:2]] <= mem_wdata;
		end else begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_cnt <= (mem_req === 1'b1 && !mem_ack) ? wait_cnt + 1 : 0;
		end
		if (mem_req === 1'b1) check("burst open", mem_open, 1'b1);
		if (mem_req === 1'b1 && prev_req) check("mem clk", mem_clk, !prev_mclk);
		prev_req <= (mem_req === 1'b1);
		prev_mclk <= mem_clk;
	end

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run

	task automatic do_reset;
		rst_n = 1'b0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
	endtask : do_reset

	// one command through the user side; data words are d, d+1, ...
	task automatic xfer(input logic wr, input logic rg, input logic [AW-1:0] a,
		input logic [LW-1:0] n, input logic [1:0] b, input logic [DW-1:0] d);
		logic [34:0] r;
		logic [1:0]  e;
		e = RESP_OKAY;
		acc_cnt = 0;
		{cmd_write, cmd_reg, cmd_addr, cmd_len, cmd_burst} = {wr, rg, a, n, b};
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1) @(negedge clk);
		@(negedge clk);
		cmd_valid = 1'b0;
		for (int i = 0; wr && i <= n; i++) begin
			wd_data = d + i;
			wd_valid = 1'b1;
			if (!rg && a + 4 * i == err_addr) e = RESP_SLVERR;
			while (wd_ready !== 1'b1) @(negedge clk);
			@(negedge clk);
		end
		wd_valid = 1'b0;
		while (done_q.size() == 0) @(negedge clk);
		r[1:0] = done_q.pop_front();
		if (wr) check("write resp", r[1:0], e);
		if (wr && !rg) check("memory word", mem_arr[a[9:2] + n], d + n);
		if (!rg) check("accesses", acc_cnt, n + 1);
		if (!wr) check("beats", rsp_q.size(), n + 1);
		for (int i = 0; !wr && i <= n; i++) begin
			r = rsp_q.pop_front();
			e = (!rg && a + 4 * i == err_addr) ? RESP_SLVERR : RESP_OKAY;
			check("read resp", r[33:32], e);
			check("read last", r[34], i == n);
			if (e == RESP_OKAY) check("read data", r[31:0], d + i);
		end
	endtask : xfer

	task automatic t_regs;
		xfer(0, 1, REG_CFG, 8'h0, BURST_INCR, CFG_RST);
		xfer(1, 1, REG_CFG, 8'h0, BURST_INCR, 32'h1234ABCD);
		check("config out", mem_cfg, 32'h1234ABCD);
		xfer(0, 1, REG_CFG, 8'h0, BURST_INCR, 32'h1234ABCD);
		xfer(0, 1, 32'h10, 8'h0, BURST_INCR, 32'h0);
		xfer(1, 1, 32'h14, 8'h0, BURST_INCR, 32'hFFFF0000);
		check("config kept", mem_cfg, 32'h1234ABCD);
	endtask : t_regs

	// prompt and slow memory, both accepted burst kinds, a fixed request
	task automatic t_bursts;
		mem_delay = 0;
		xfer(1, 0, 32'h100, 8'h3, BURST_INCR, 32'hA0);
		mem_delay = 3;
		xfer(0, 0, 32'h100, 8'h3, BURST_INCR, 32'hA0);
		xfer(1, 0, 32'h200, 8'h3, BURST_WRAP, 32'hB0);
		xfer(0, 0, 32'h200, 8'h0, BURST_INCR, 32'hB0);
		xfer(0, 0, 32'h104, 8'h1, BURST_FIXED, 32'hA1);
	endtask : t_bursts

	// a long burst against slow memory must fill the buffer until it refuses
	task automatic t_fill;
		mem_delay = 3;
		full_seen = 1'b0;
		xfer(1, 0, 32'h0, 8'hFF, BURST_INCR, 32'hC000);
		check("buffer full", full_seen, 1'b1);
		mem_delay = 0;
		xfer(0, 0, 32'h0, 8'hFF, BURST_INCR, 32'hC000);
	endtask : t_fill

	task automatic t_error;
		err_addr = 32'h108;
		xfer(1, 0, 32'h100, 8'h3, BURST_INCR, 32'hD0);
		xfer(0, 0, 32'h100, 8'h3, BURST_INCR, 32'hD0);
		err_addr = 32'hFFFFFFF0;
	endtask : t_error

	task automatic t_reset;
		do_reset();
		xfer(0, 1, REG_CFG, 8'h0, BURST_INCR, CFG_RST);
		check("config reset", mem_cfg, CFG_RST);
	endtask : t_reset

	initial begin
		clk = 1'b0;
		{rst_n, cmd_valid, cmd_write, cmd_reg, wd_valid} = 5'h0;
		{cmd_addr, cmd_len, cmd_burst, wd_data} = '0;
		{mem_ack, mem_err, mem_rdata, mem_delay} = '0;
		{mem_open, full_seen, prev_req, prev_mclk} = 4'h0;
		err_addr = 32'hFFFFFFF0;
		do_reset();
		t_regs();
		t_bursts();
		t_fill();
		t_error();
		t_reset();
		complete_run();
	end
endmodule : aemf_bench
